/* File: dv/vrc_top_tb_top.sv */
/*
 * self-checking bench for the voltage reference control register.
 * assumes vrc_pkg and vrc_top compiled first; bench drives the sfr bus itself.
 */
`timescale 1ns/1ps
`define CHK(nm, exp, got) begin n_checks++; if ((got) !== (exp)) begin errors++; \
  $display("FAIL %s expected %0h seen %0h", nm, exp, got); end end
module vrc_top_tb_top;
  import vrc_pkg::*;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic [7:0] addr = 8'h00;
  logic [7:0] wdata = 8'h00;
  logic wr = 1'b0, rd = 1'b0, cen = 1'b0, oen = 1'b0, den = 1'b0;
  logic [7:0] rdata, q;
  logic hit, buf_o, tmp, hiz, rb, cb, bg, h;
  vrc_src_e src;
  int errors = 0;
  int n_checks = 0;
  vrc_top u_dut (.clk_i(clk_i), .rst_i(rst_i), .sfr_addr_i(addr), .sfr_wdata_i(wdata), .sfr_wr_i(wr),
    .sfr_rd_i(rd), .converter_enable_i(cen), .internal_osc_enable_i(oen), .current_dac_enable_i(den),
    .sfr_rdata_o(rdata), .sfr_hit_o(hit), .reference_source_select_o(src), .reference_buffer_enable_o(buf_o),
    .temp_sensor_enable_o(tmp), .temp_sensor_hiz_o(hiz), .ref_bias_on_o(rb), .conv_bias_on_o(cb),
    .bias_gen_on_o(bg));
  // ==========================================================
  // shared bus cycle: one-cycle strobe; read data stands only in the cycle after the strobe edge
  task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] d);
    addr = a; wdata = d; wr = w; rd = !w;
    @(posedge clk_i); #1 wr = 1'b0; rd = 1'b0;
    q = rdata;
    h = hit;
    // three more edges so registered control outputs have landed
    repeat (3) @(posedge clk_i);
    #1;
  endtask : bus
  // ==========================================================
  // scenarios
  // port mode and skip setup sit outside this block; bench touches this register and unmapped address 8'hd0
  task automatic t_reset();
    `CHK("src", 1'b0, src)
    `CHK("buf", 1'b0, buf_o)
    `CHK("temp", 1'b0, tmp)
    `CHK("hiz", 1'b1, hiz)
    `CHK("bias", 3'b000, {rb, cb, bg})
    bus(1'b0, VRC_REF_CTRL_ADDR, 8'h00);
    `CHK("rd reset", 8'h00, q)
    `CHK("hit", 1'b1, h)
    $display("test reset done");
  endtask : t_reset
  // every control value against every foreign enable mix; upper data bits junk
  task automatic t_decode();
    logic [3:0] v;
    logic e_ref, e_conv;
    for (int i = 0; i < 128; i++) begin
      v = 4'(i);
      bus(1'b1, VRC_REF_CTRL_ADDR, {~v, v});
      {den, oen, cen} = 3'(i >> 4);
      repeat (2) @(posedge clk_i);
      #1 e_ref = v[0] | v[2] | den;
      e_conv = v[1] | cen | oen;
      `CHK("src", v[3], src)
      `CHK("buf", v[0], buf_o)
      `CHK("temp", {v[2], ~v[2]}, {tmp, hiz})
      `CHK("ref bias", e_ref, rb)
      `CHK("conv bias", e_conv, cb)
      `CHK("bias gen", e_ref | e_conv, bg)
      bus(1'b0, VRC_REF_CTRL_ADDR, 8'h00);
      `CHK("readback", {4'h0, v}, q)
    end
    $display("test decode done");
  endtask : t_decode
  // unmapped address: write ignored, read empty, no hit
  task automatic t_unmapped();
    bus(1'b1, 8'hd0, 8'h00);
    `CHK("src kept", 1'b1, src)
    `CHK("buf kept", 1'b1, buf_o)
    bus(1'b0, 8'hd0, 8'h00);
    `CHK("rd other", 9'h000, {h, q})
    // software drops buffer enable when reference unused
    bus(1'b1, VRC_REF_CTRL_ADDR, 8'h0e);
    `CHK("buf off", 1'b0, buf_o)
    `CHK("src held", 1'b1, src)
    $display("test unmapped done");
  endtask : t_unmapped
  // ==========================================================
  // verdict
  task automatic results();
    $display("checks %0d errors %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : results
  // clock, 200 MHz
  initial begin
    forever #2.5 clk_i = ~clk_i;
  end
  // watchdog, well beyond the ~1300 cycles the tests need
  initial begin
    #100000;
    errors++;
    results();
  end
  // main sequence
  initial begin
    repeat (10) @(posedge clk_i);
    #1 rst_i = 1'b0;
    @(posedge clk_i);
    #1 t_reset();
    t_decode();
    t_unmapped();
    results();
  end
endmodule : vrc_top_tb_top

/* File: logic/vrc_bias_dec.sv */
/*
 * registered decoder from control bits and foreign peripheral enables to
 * the analog enable lines. assumes peripheral enables are synchronous.
 */
`timescale 1ns/1ps
module vrc_bias_dec (
  input wire logic clk_i,
  input wire logic rst_i,
  vrc_ctrl_if.dec ctrl,
  input wire logic converter_enable_i,
  input wire logic internal_osc_enable_i,
  input wire logic current_dac_enable_i,
  output logic ref_bias_on_o,
  output logic conv_bias_on_o,
  output logic bias_gen_on_o
);
  // ==========================================================
  // enable decode
  logic ref_bias_nxt;
  logic conv_bias_nxt;
  assign ref_bias_nxt = ctrl.buf_en | ctrl.temp_en | current_dac_enable_i;
  assign conv_bias_nxt = ctrl.bias_en | converter_enable_i | internal_osc_enable_i;
  // registered so outputs come from flops
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      ref_bias_on_o <= 1'b0;
      conv_bias_on_o <= 1'b0;
      bias_gen_on_o <= 1'b0;
    end else begin
      ref_bias_on_o <= ref_bias_nxt;
      conv_bias_on_o <= conv_bias_nxt;
      bias_gen_on_o <= ref_bias_nxt | conv_bias_nxt;
    end
  end
  // ==========================================================
  // checks
  bias_any_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (converter_enable_i | internal_osc_enable_i | current_dac_enable_i | ctrl.bias_en | ctrl.temp_en)
    |=> bias_gen_on_o) else $error("bias generator not on");
  ref_bias_a: assert property (@(posedge clk_i) disable iff (rst_i)
    ref_bias_on_o == $past(ctrl.buf_en | ctrl.temp_en | current_dac_enable_i))
    else $error("reference bias mismatch");
  conv_bias_a: assert property (@(posedge clk_i) disable iff (rst_i)
    conv_bias_on_o == $past(ctrl.bias_en | converter_enable_i | internal_osc_enable_i))
    else $error("converter bias mismatch");
endmodule : vrc_bias_dec

/* File: logic/vrc_ctrl_if.sv */
/*
 * interface carrying the four stored control bits from the register
 * bank to the enable decoder. assumes both ends share clk_i.
 */
`timescale 1ns/1ps
interface vrc_ctrl_if;
  logic buf_en;
  logic bias_en;
  logic temp_en;
  logic src_sel;
  modport bank (output buf_en, output bias_en, output temp_en, output src_sel);
  modport dec (input buf_en, input bias_en, input temp_en, input src_sel);
endinterface : vrc_ctrl_if

/* File: logic/vrc_pkg.sv */
/*
 * package for the voltage reference control block: register address,
 * field positions, reset value and source select encoding.
 * assumes an 8-bit special-function-register bus with byte addresses.
 */
package vrc_pkg;
  // ==========================================================
  // register map
  localparam logic [7:0] VRC_REF_CTRL_ADDR = 8'hd1;
  localparam logic [7:0] VRC_REF_CTRL_RESET = 8'h00;
  localparam logic [7:0] VRC_REF_CTRL_MASK = 8'h0f;
  // ==========================================================
  // field positions
  localparam int VRC_BUF_EN_BIT = 0;
  localparam int VRC_BIAS_EN_BIT = 1;
  localparam int VRC_TEMP_EN_BIT = 2;
  localparam int VRC_SRC_SEL_BIT = 3;
  // ==========================================================
  // reference source encoding
  typedef enum logic {
    VRC_SRC_PIN = 1'b0,
    VRC_SRC_SUPPLY = 1'b1
  } vrc_src_e;
endpackage : vrc_pkg

/* File: logic/vrc_top.sv */
/*
 * voltage reference control register and its enable outputs.
 * assumes a simple synchronous sfr bus: one-cycle wr/rd strobes, 8-bit address.
 */
// Contract
// - source select 0 picks reference pin, 1 picks supply
// - bias generator on when any user or manual bias set
// - buffer enable drives internal reference onto pin
// - temp sensor on when set, else output high impedance
// - reference bias on with buffer, sensor or current DAC
// - converter bias on with manual, converter or oscillator
`timescale 1ns/1ps
module vrc_top
  import vrc_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [7:0] sfr_addr_i,
  input wire logic [7:0] sfr_wdata_i,
  input wire logic sfr_wr_i,
  input wire logic sfr_rd_i,
  input wire logic converter_enable_i,
  input wire logic internal_osc_enable_i,
  input wire logic current_dac_enable_i,
  output logic [7:0] sfr_rdata_o,
  output logic sfr_hit_o,
  output vrc_pkg::vrc_src_e reference_source_select_o,
  output logic reference_buffer_enable_o,
  output logic temp_sensor_enable_o,
  output logic temp_sensor_hiz_o,
  output logic ref_bias_on_o,
  output logic conv_bias_on_o,
  output logic bias_gen_on_o
);
  import vrc_pkg::*;
  // ==========================================================
  // control register
  logic [3:0] ctrl_r;
  logic sel_wr;
  assign sel_wr = sfr_wr_i && (sfr_addr_i == VRC_REF_CTRL_ADDR);
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      ctrl_r <= VRC_REF_CTRL_RESET[3:0];
    end else if (sel_wr) begin
      ctrl_r <= sfr_wdata_i[3:0];
    end
  end
  // ==========================================================
  // read port, registered; unmapped addresses read zero
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      sfr_rdata_o <= 8'h00;
      sfr_hit_o <= 1'b0;
    end else begin
      sfr_hit_o <= sfr_rd_i && (sfr_addr_i == VRC_REF_CTRL_ADDR);
      if (sfr_rd_i && (sfr_addr_i == VRC_REF_CTRL_ADDR)) begin
        sfr_rdata_o <= {4'h0, ctrl_r} & VRC_REF_CTRL_MASK;
      end else begin
        sfr_rdata_o <= 8'h00;
      end
    end
  end
  // ==========================================================
  // analog control lines, one cycle after the register
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      reference_source_select_o <= VRC_SRC_PIN;
      reference_buffer_enable_o <= 1'b0;
      temp_sensor_enable_o <= 1'b0;
      temp_sensor_hiz_o <= 1'b1;
    end else begin
      reference_source_select_o <= vrc_src_e'(ctrl_r[VRC_SRC_SEL_BIT]);
      reference_buffer_enable_o <= ctrl_r[VRC_BUF_EN_BIT];
      temp_sensor_enable_o <= ctrl_r[VRC_TEMP_EN_BIT];
      temp_sensor_hiz_o <= ~ctrl_r[VRC_TEMP_EN_BIT];
    end
  end
  // ==========================================================
  // bias decode
  vrc_ctrl_if ctrl_bus ();
  assign ctrl_bus.buf_en = ctrl_r[VRC_BUF_EN_BIT];
  assign ctrl_bus.bias_en = ctrl_r[VRC_BIAS_EN_BIT];
  assign ctrl_bus.temp_en = ctrl_r[VRC_TEMP_EN_BIT];
  assign ctrl_bus.src_sel = ctrl_r[VRC_SRC_SEL_BIT];
  vrc_bias_dec u_dec (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .ctrl(ctrl_bus),
    .converter_enable_i(converter_enable_i),
    .internal_osc_enable_i(internal_osc_enable_i),
    .current_dac_enable_i(current_dac_enable_i),
    .ref_bias_on_o(ref_bias_on_o),
    .conv_bias_on_o(conv_bias_on_o),
    .bias_gen_on_o(bias_gen_on_o)
  );
  // ==========================================================
  // checks
  src_select_a: assert property (@(posedge clk_i) disable iff (rst_i)
    sel_wr |=> ##1 (reference_source_select_o == vrc_src_e'($past(sfr_wdata_i[3], 2))))
    else $error("source select did not follow write");
  buf_drive_a: assert property (@(posedge clk_i) disable iff (rst_i)
    sel_wr |=> ##1 (reference_buffer_enable_o == $past(sfr_wdata_i[0], 2)))
    else $error("buffer enable did not follow write");
  sensor_hiz_a: assert property (@(posedge clk_i) disable iff (rst_i)
    temp_sensor_hiz_o != temp_sensor_enable_o)
    else $error("sensor float state wrong");
  read_upper_a: assert property (@(posedge clk_i) disable iff (rst_i)
    sfr_rdata_o[7:4] == 4'h0) else $error("upper bits not zero");
  read_back_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (sfr_rd_i && sfr_addr_i == VRC_REF_CTRL_ADDR && !sfr_wr_i) |=> sfr_rdata_o[3:0] == $past(ctrl_r))
    else $error("read back mismatch");
endmodule : vrc_top
